// ==== core/sprf_regs.vh ====
// Constants of the signaling payload framer: sizes, header values, timing.
// Assumes inclusion by bare name from the core design files only.
`ifndef SPRF_REGS_VH
`define SPRF_REGS_VH

// ************************
// Payload structure sizes in bytes
// ************************
`define SPRF_LEN_BYTES     17'h00002
`define SPRF_CRC_BYTES     17'h00002
`define SPRF_BASIC_BYTES   16'h0019
`define SPRF_TAIL_BYTES    17'h00004

// ************************
// Packet size limits in bytes, and index of the last header byte
// ************************
`define SPRF_MTU_BYTES     16'h05DC
`define SPRF_IP_HDR_BYTES  16'h0014
`define SPRF_UDP_HDR_BYTES 16'h0008
`define SPRF_RTP_HDR_BYTES 16'h000C
`define SPRF_EXT_RSV_BYTES 16'h0020
`define SPRF_FRAG_MAX      (`SPRF_MTU_BYTES - `SPRF_IP_HDR_BYTES - `SPRF_UDP_HDR_BYTES - `SPRF_RTP_HDR_BYTES)
`define SPRF_HDR_LAST_IDX  4'hB

// ************************
// Addressing
// ************************
`define SPRF_DST_ADDR      32'hEF003330
`define SPRF_BASE_PORT     16'h7570
`define SPRF_PORT_STEP     16'h0064

// ************************
// RTP header field values
// ************************
`define SPRF_RTP_VER       2'h2
`define SPRF_RTP_PAD       1'h0
`define SPRF_RTP_CC        4'h0
`define SPRF_RTP_PT        7'h4D
`define SPRF_RTP_SSRC      32'h00000000
`define SPRF_SEQ_INIT      16'h0000

// ************************
// Timestamp field positions
// ************************
`define SPRF_TS_SEC_MSB    21
`define SPRF_TS_NS_MSB     29
`define SPRF_TS_NS_LSB     20

// ************************
// Check word
// ************************
`define SPRF_CRC_POLY      16'h1021
`define SPRF_CRC_INIT      16'hFFFF

`endif

// ==== core/sprf_buf.v ====
// Two-entry buffer with valid and ready on both sides.
// Assumes one clock and a synchronous active-high reset.
module sprf_buf #(
    parameter WIDTH = 8
) (
    // Clock and reset
    input  wire             clk,
    input  wire             reset,
    // Filling side
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output reg              in_ready,
    // Draining side
    output reg  [WIDTH-1:0] out_data,
    output reg              out_valid,
    input  wire             out_ready
);

    reg  [WIDTH-1:0] spare;
    reg              spare_valid;
    wire             push;
    wire             pop;
    wire [1:0]       fill;
    reg  [1:0]       next_fill;

    // Handshakes and occupancy
    assign push = in_valid & in_ready;
    assign pop  = out_valid & out_ready;
    assign fill = {1'b0, out_valid} + {1'b0, spare_valid};

    // Occupancy after this cycle
    always @* begin
        next_fill = fill;
        if (push & ~pop) begin
            next_fill = fill + 2'h1;
        end else if (pop & ~push) begin
            next_fill = fill - 2'h1;
        end
    end

    // Head and spare entries, ready from a flop
    always @(posedge clk) begin
        if (reset) begin
            out_data    <= {WIDTH{1'b0}};
            out_valid   <= 1'b0;
            spare       <= {WIDTH{1'b0}};
            spare_valid <= 1'b0;
            in_ready    <= 1'b0;
        end else begin
            in_ready <= (next_fill != 2'h2);
            if (pop) begin
                if (spare_valid) begin
                    out_data    <= spare;
                    spare       <= in_data;
                    spare_valid <= push;
                end else begin
                    out_data  <= in_data;
                    out_valid <= push;
                end
            end else if (push) begin
                if (out_valid) begin
                    spare       <= in_data;
                    spare_valid <= 1'b1;
                end else begin
                    out_data  <= in_data;
                    out_valid <= 1'b1;
                end
            end
        end
    end

endmodule

// ==== core/sprf_framer.v ====
// Signaling payload framer: builds length, body and check word, and cuts
// the payload into RTP packets with header bytes ahead of each fragment.
// Assumes a downstream stage that adds IP/UDP headers from the sideband
// and inserts any signing extension right after header byte 11.
`include "sprf_regs.vh"

module sprf_framer (
    // Clock and reset
    input  wire        clk,
    input  wire        reset,
    // Payload request
    input  wire        start,
    input  wire [15:0] body_len,
    input  wire [31:0] boot_seconds,
    input  wire [31:0] boot_nanoseconds,
    input  wire [1:0]  channel,
    input  wire        sign_en,
    input  wire [10:0] frag_max,
    // Request status
    output reg         busy,
    output reg         len_err,
    output reg  [15:0] set_count,
    output reg  [7:0]  set_packets,
    // Body byte stream
    input  wire [7:0]  in_data,
    input  wire        in_valid,
    output wire        in_ready,
    // Packet byte stream
    output reg  [7:0]  out_data,
    output reg         out_valid,
    output reg         out_first,
    output reg         out_last,
    input  wire        out_ready,
    // Per-packet sideband
    output reg  [31:0] pkt_dst_addr,
    output reg  [15:0] pkt_dst_port,
    output reg  [15:0] pkt_len,
    output reg         pkt_ext
);

    // ************************
    // States
    // ************************
    localparam S_IDLE = 2'h0;
    localparam S_HDR  = 2'h1;
    localparam S_PAY  = 2'h2;
    localparam [31:0] SSRC_WORD = `SPRF_RTP_SSRC;

    // ************************
    // Functions
    // ************************

    // One byte of the check word, most significant bit first
    function [15:0] crc_step;
        input [15:0] c;
        input [7:0]  d;
        integer      i;
        reg   [15:0] r;
        begin
            r = c;
            for (i = 0; i < 8; i = i + 1) begin
                if (r[15] ^ d[7-i]) begin
                    r = {r[14:0], 1'b0} ^ `SPRF_CRC_POLY;
                end else begin
                    r = {r[14:0], 1'b0};
                end
            end
            crc_step = r;
        end
    endfunction

    // RTP header byte at a given index
    function [7:0] hdr_byte;
        input [3:0]  idx;
        input        ext;
        input        mark;
        input [15:0] seq;
        input [31:0] ts;
        begin
            case (idx)
                4'h0: hdr_byte = {`SPRF_RTP_VER, `SPRF_RTP_PAD, ext, `SPRF_RTP_CC};
                4'h1: hdr_byte = {mark, `SPRF_RTP_PT};
                4'h2: hdr_byte = seq[15:8];
                4'h3: hdr_byte = seq[7:0];
                4'h4: hdr_byte = ts[31:24];
                4'h5: hdr_byte = ts[23:16];
                4'h6: hdr_byte = ts[15:8];
                4'h7: hdr_byte = ts[7:0];
                4'h8: hdr_byte = SSRC_WORD[31:24];
                4'h9: hdr_byte = SSRC_WORD[23:16];
                4'hA: hdr_byte = SSRC_WORD[15:8];
                4'hB: hdr_byte = SSRC_WORD[7:0];
                default: hdr_byte = 8'h00;
            endcase
        end
    endfunction

    // ************************
    // Registers and wires
    // ************************
    reg  [1:0]  state;
    reg  [15:0] blen;
    reg  [16:0] total;
    reg  [16:0] ppos;
    reg  [15:0] crc;
    reg  [31:0] ts;
    reg  [15:0] seq;
    reg         marker;
    reg         ext;
    reg  [1:0]  chan;
    reg  [10:0] frag_lim;
    reg  [10:0] fleft;
    reg  [3:0]  hcnt;

    wire [7:0]  b_data;
    wire        b_valid;
    wire        b_ready;
    wire        load_ok;
    wire [16:0] remain;
    wire [10:0] frag_now;
    wire [16:0] body_end;
    wire        in_len;
    wire        in_body;
    wire [7:0]  pay_byte;
    wire        emit_pay;
    wire        emit_hdr;
    wire [15:0] lim_cap;
    wire [10:0] lim_sel;

    // ************************
    // Input buffer
    // ************************

    // Body bytes wait here while the packet side stalls
    sprf_buf #(
        .WIDTH     (8)
    ) u_buf (
        .clk       (clk),
        .reset     (reset),
        .in_data   (in_data),
        .in_valid  (in_valid),
        .in_ready  (in_ready),
        .out_data  (b_data),
        .out_valid (b_valid),
        .out_ready (b_ready)
    );

    // ************************
    // Fragment sizing
    // ************************

    // Room left for payload once headers and extension are counted
    assign lim_cap = sign_en ? (`SPRF_FRAG_MAX - `SPRF_EXT_RSV_BYTES) : `SPRF_FRAG_MAX;
    assign lim_sel = ((frag_max == 11'h000) || ({5'h00, frag_max} > lim_cap)) ? lim_cap[10:0] : frag_max;

    // Next fragment: full size or the smaller remainder
    assign remain   = total - ppos;
    assign frag_now = (remain < {6'h00, frag_lim}) ? remain[10:0] : frag_lim;

    // ************************
    // Payload byte source
    // ************************

    // Length first, then body bytes, then the check word
    assign body_end = {1'b0, blen} + `SPRF_LEN_BYTES;
    assign in_len   = (ppos < `SPRF_LEN_BYTES);
    assign in_body  = ~in_len & (ppos < body_end);
    assign pay_byte = in_len ? (ppos[0] ? blen[7:0] : blen[15:8]) :
                      in_body ? b_data :
                      (ppos == body_end) ? crc[15:8] : crc[7:0];

    // Output register free, and data on hand
    assign load_ok  = ~out_valid | out_ready;
    assign emit_hdr = (state == S_HDR) & load_ok;
    assign emit_pay = (state == S_PAY) & load_ok & (~in_body | b_valid);
    assign b_ready  = (state == S_PAY) & load_ok & in_body;

    // ************************
    // Sequencer
    // ************************

    // Request capture, header bytes, then fragment bytes
    always @(posedge clk) begin
        if (reset) begin
            state    <= S_IDLE;
            blen     <= 16'h0000;
            total    <= 17'h00000;
            ppos     <= 17'h00000;
            crc      <= `SPRF_CRC_INIT;
            ts       <= 32'h00000000;
            seq      <= `SPRF_SEQ_INIT;
            marker   <= 1'b0;
            ext      <= 1'b0;
            chan     <= 2'h0;
            frag_lim <= 11'h000;
            fleft    <= 11'h000;
            hcnt     <= 4'h0;
            busy     <= 1'b0;
            len_err  <= 1'b0;
        end else begin
            len_err <= 1'b0;
            case (state)
                S_IDLE: begin
                    if (start && (body_len < `SPRF_BASIC_BYTES)) begin
                        len_err <= 1'b1;
                    end else if (start) begin
                        blen     <= body_len;
                        total    <= {1'b0, body_len} + `SPRF_TAIL_BYTES;
                        ppos     <= 17'h00000;
                        crc      <= `SPRF_CRC_INIT;
                        ts       <= {boot_seconds[`SPRF_TS_SEC_MSB:0],
                                     boot_nanoseconds[`SPRF_TS_NS_MSB:`SPRF_TS_NS_LSB]};
                        marker   <= 1'b1;
                        ext      <= sign_en;
                        chan     <= channel;
                        frag_lim <= lim_sel;
                        hcnt     <= 4'h0;
                        busy     <= 1'b1;
                        state    <= S_HDR;
                    end
                end
                S_HDR: begin
                    if (emit_hdr) begin
                        if (hcnt == 4'h0) begin
                            fleft <= frag_now;
                        end
                        if (hcnt == `SPRF_HDR_LAST_IDX) begin
                            hcnt  <= 4'h0;
                            state <= S_PAY;
                        end else begin
                            hcnt <= hcnt + 4'h1;
                        end
                    end
                end
                S_PAY: begin
                    if (emit_pay) begin
                        ppos  <= ppos + 17'h00001;
                        fleft <= fleft - 11'h001;
                        if (ppos < body_end) begin
                            crc <= crc_step(crc, pay_byte);
                        end
                        if (fleft == 11'h001) begin
                            marker <= 1'b0;
                            seq    <= seq + 16'h0001;
                            if (ppos == (total - 17'h00001)) begin
                                busy  <= 1'b0;
                                state <= S_IDLE;
                            end else begin
                                state <= S_HDR;
                            end
                        end
                    end
                end
                default: begin
                    state <= S_IDLE;
                    busy  <= 1'b0;
                end
            endcase
        end
    end

    // ************************
    // Packet byte output
    // ************************

    // Output register loads only when empty or being taken
    always @(posedge clk) begin
        if (reset) begin
            out_data  <= 8'h00;
            out_valid <= 1'b0;
            out_first <= 1'b0;
            out_last  <= 1'b0;
        end else if (emit_hdr) begin
            out_data  <= hdr_byte(hcnt, ext, marker, seq, ts);
            out_valid <= 1'b1;
            out_first <= (hcnt == 4'h0);
            out_last  <= 1'b0;
        end else if (emit_pay) begin
            out_data  <= pay_byte;
            out_valid <= 1'b1;
            out_first <= 1'b0;
            out_last  <= (fleft == 11'h001);
        end else if (out_ready) begin
            out_valid <= 1'b0;
            out_first <= 1'b0;
            out_last  <= 1'b0;
        end
    end

    // ************************
    // Per-packet sideband
    // ************************

    // Loaded with the first header byte, held to the packet's end
    always @(posedge clk) begin
        if (reset) begin
            pkt_dst_addr <= 32'h00000000;
            pkt_dst_port <= 16'h0000;
            pkt_len      <= 16'h0000;
            pkt_ext      <= 1'b0;
        end else if (emit_hdr && (hcnt == 4'h0)) begin
            pkt_dst_addr <= `SPRF_DST_ADDR;
            pkt_dst_port <= `SPRF_BASE_PORT + ({14'h0000, chan} * `SPRF_PORT_STEP);
            pkt_len      <= `SPRF_RTP_HDR_BYTES + {5'h00, frag_now};
            pkt_ext      <= ext;
        end
    end

    // ************************
    // Set statistics
    // ************************

    // Sets finished and packets of the current set
    always @(posedge clk) begin
        if (reset) begin
            set_count   <= 16'h0000;
            set_packets <= 8'h00;
        end else if ((state == S_IDLE) && start && (body_len >= `SPRF_BASIC_BYTES)) begin
            set_packets <= 8'h00;
        end else if (emit_hdr && (hcnt == 4'h0)) begin
            set_packets <= set_packets + 8'h01;
        end else if (emit_pay && (fleft == 11'h001) && (ppos == (total - 17'h00001))) begin
            set_count <= set_count + 16'h0001;
        end
    end

endmodule

// ==== testbench/sprf_framer_sva.sv ====
// Checker for the signaling payload framer, seeing its top ports only.
// Assumes one clock, synchronous active-high reset, bound below.
module sprf_framer_sva (
    // Clock and reset
    input logic        clk,
    input logic        reset,
    // Request
    input logic        start,
    input logic [15:0] body_len,
    input logic [31:0] boot_seconds,
    input logic [31:0] boot_nanoseconds,
    input logic [1:0]  channel,
    input logic        sign_en,
    input logic        busy,
    input logic        len_err,
    // Packet stream and sideband
    input logic [7:0]  out_data,
    input logic        out_valid,
    input logic        out_first,
    input logic        out_last,
    input logic        out_ready,
    input logic [31:0] pkt_dst_addr,
    input logic [15:0] pkt_dst_port,
    input logic [15:0] pkt_len,
    input logic        pkt_ext
);
    // ************************
    // Helper state
    // ************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    logic [11:0] hx;
    logic [31:0] ts;
    logic [15:0] port, len, sq;
    logic [7:0]  sh;
    logic        mk, lm, hv, sg;
    wire  [11:0] ix   = out_first ? 12'h000 : hx;
    wire         acc  = out_valid && out_ready;
    wire         take = start && !busy && body_len >= 16'h0019;
    // Byte index, captured request fields, marker and sequence
    always @(posedge clk) begin
        if (reset) begin
            hx <= 12'h000;
            mk <= 1'b0;
            hv <= 1'b0;
        end else begin
            if (acc) hx <= ix + 12'h001;
            if (take) begin
                ts <= {boot_seconds[21:0], boot_nanoseconds[29:20]};
                port <= 16'h7570 + 16'h0064 * channel;
                len <= body_len;
                sg <= sign_en;
                mk <= 1'b1;
            end else if (acc && ix == 12'h001) mk <= 1'b0;
            if (acc && ix == 12'h001) lm <= out_data[7];
            if (acc && ix == 12'h002) sh <= out_data;
            if (acc && ix == 12'h003) sq <= {sh, out_data};
            if (acc && ix == 12'h003) hv <= 1'b1;
        end
    end
    // ************************
    // Assertions
    // ************************
    a_refuse_short: assert property (start && !busy && body_len < 16'h0019 |=> len_err && !busy)
        else $error("short request not refused");
    a_first_byte: assert property (out_valid && out_first |-> out_data == {2'h2, 1'b0, pkt_ext, 4'h0})
        else $error("bad first header byte");
    a_marker_type: assert property (out_valid && ix == 12'h001 |-> out_data == {mk, 7'h4D})
        else $error("bad marker or payload type");
    a_seq_step: assert property (acc && hv && ix == 12'h003 |-> {sh, out_data} == sq + 16'h0001)
        else $error("sequence did not step by one");
    a_stamp_bytes: assert property (out_valid && ix >= 12'h004 && ix <= 12'h007
        |-> out_data == 8'(ts >> (12'h008 * (12'h007 - ix))))
        else $error("timestamp byte wrong");
    a_ssrc_zero: assert property (out_valid && ix >= 12'h008 && ix <= 12'h00B |-> out_data == 8'h00)
        else $error("source identifier not zero");
    a_len_field: assert property (out_valid && lm && (ix == 12'h00C || ix == 12'h00D)
        |-> out_data == (ix == 12'h00C ? len[15:8] : len[7:0]))
        else $error("length field wrong");
    a_dest_addr: assert property (out_valid |-> pkt_dst_addr == 32'hEF003330)
        else $error("destination address wrong");
    a_port_ext: assert property (out_valid && out_first |-> pkt_dst_port == port && pkt_ext == sg)
        else $error("port or extension flag wrong");
    a_mtu_limit: assert property (out_valid && out_first |-> pkt_len <= (pkt_ext ? 16'h05A0 : 16'h05C0))
        else $error("packet exceeds transfer unit");
    a_len_match: assert property (out_valid && out_last |-> pkt_len == {4'h0, ix} + 16'h0001)
        else $error("packet length and last byte disagree");
    a_hold_byte: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
        else $error("stalled byte changed");
endmodule

bind sprf_framer sprf_framer_sva i_sva (
    .clk(clk), .reset(reset), .start(start), .body_len(body_len), .boot_seconds(boot_seconds),
    .boot_nanoseconds(boot_nanoseconds), .channel(channel), .sign_en(sign_en), .busy(busy),
    .len_err(len_err), .out_data(out_data), .out_valid(out_valid), .out_first(out_first),
    .out_last(out_last), .out_ready(out_ready), .pkt_dst_addr(pkt_dst_addr),
    .pkt_dst_port(pkt_dst_port), .pkt_len(pkt_len), .pkt_ext(pkt_ext)
);

// ==== testbench/sprf_cons.sv ====
// Consumer model: paces ready, rebuilds payload sets, checks check word.
// Assumes an in-order link from the framer's packet byte stream.
module sprf_cons (
    // Clock, reset and pacing
    input  logic       clk,
    input  logic       reset,
    input  logic       stall,
    // Packet byte stream
    input  logic [7:0] out_data,
    input  logic       out_valid,
    input  logic       out_first,
    output logic       out_ready,
    // Reassembly status
    output logic       set_done,
    output logic       set_drop,
    output logic       crc_bad
);
    // ************************
    // Reassembly
    // ************************
    logic [10:0] hx, pc;
    logic [15:0] nsq, len, cnt, c;
    logic [7:0]  shi, rhi;
    logic        hv, act, mk;
    wire  [10:0] ix  = out_first ? 11'h000 : hx;
    wire  [15:0] sqn = {shi, out_data};
    function automatic logic [15:0] stp(logic [15:0] a, logic [7:0] d);
        for (int i = 7; i >= 0; i--)
            a = {a[14:0], 1'b0} ^ ((a[15] ^ d[i]) ? 16'h1021 : 16'h0000);
        return a;
    endfunction
    // Ready mostly low while stalling
    always @(posedge clk) begin
        pc <= reset ? 11'h000 : pc + 11'h001;
        out_ready <= !reset && (!stall || pc[2:0] == 3'h0);
    end
    // Header parse and payload collection
    always @(posedge clk) begin
        set_done <= 1'b0;
        set_drop <= 1'b0;
        crc_bad <= 1'b0;
        if (reset) begin
            hv <= 1'b0;
            act <= 1'b0;
        end else if (out_valid && out_ready) begin
            hx <= ix + 11'h001;
            if (ix == 11'h001) mk <= out_data[7];
            if (ix == 11'h002) shi <= out_data;
            if (ix == 11'h003) begin
                nsq <= sqn + 16'h0001;
                hv <= 1'b1;
                // Gap or early marker loses the set
                set_drop <= act && ((hv && sqn != nsq) || mk);
                act <= mk || (act && !(hv && sqn != nsq));
                cnt <= mk ? 16'h0000 : cnt;
                c <= mk ? 16'hFFFF : c;
                len <= mk ? 16'h7FFF : len;
            end
            // In-order link: arrival order is sequence order
            if (ix >= 11'h00C && act) begin
                cnt <= cnt + 16'h0001;
                if (cnt == 16'h0000) len[15:8] <= out_data;
                if (cnt == 16'h0001) len[7:0] <= out_data;
                if (cnt < 16'h0002 || cnt < len + 16'h0002) c <= stp(c, out_data);
                if (cnt == len + 16'h0002) rhi <= out_data;
                if (cnt == len + 16'h0003) begin
                    set_done <= 1'b1;
                    act <= 1'b0;
                    crc_bad <= c != {rhi, out_data};
                end
            end
        end
    end
endmodule

// ==== testbench/tb_top.sv ====
// Testbench for the signaling payload framer with a consumer model.
// Assumes a 125 MHz clock and synchronous active-high reset.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ************************
    // Signals and tables
    // ************************
    logic        clk, reset, start, sign_en, in_valid, in_ready, stall, busy, len_err;
    logic        out_valid, out_first, out_last, out_ready, pkt_ext, set_done, set_drop, crc_bad, saw_full;
    logic [15:0] body_len, set_count, pkt_dst_port, pkt_len;
    logic [31:0] boot_seconds, boot_nanoseconds, pkt_dst_addr;
    logic [1:0]  channel;
    logic [10:0] frag_max;
    logic [7:0]  in_data, out_data, set_packets;
    logic [8:0]  e, expq[$];
    logic [32:0] sbq[$];
    int          error_cnt, tests_run, dones, seq, k;
    int          nt[5] = '{25, 60, 40, 1500, 1460};
    int          ft[5] = '{0, 20, 11, 0, 2047};
    int          ct[5] = '{0, 3, 1, 2, 0};
    logic        gt[5] = '{0, 1, 0, 1, 0};
    logic        st[5] = '{0, 1, 0, 0, 1};
    sprf_framer i_dut (.clk(clk), .reset(reset), .start(start), .body_len(body_len), .boot_seconds(boot_seconds),
        .boot_nanoseconds(boot_nanoseconds), .channel(channel), .sign_en(sign_en), .frag_max(frag_max),
        .busy(busy), .len_err(len_err), .set_count(set_count), .set_packets(set_packets), .in_data(in_data),
        .in_valid(in_valid), .in_ready(in_ready), .out_data(out_data), .out_valid(out_valid),
        .out_first(out_first), .out_last(out_last), .out_ready(out_ready), .pkt_dst_addr(pkt_dst_addr),
        .pkt_dst_port(pkt_dst_port), .pkt_len(pkt_len), .pkt_ext(pkt_ext));
    sprf_cons i_cons (.clk(clk), .reset(reset), .stall(stall), .out_data(out_data), .out_valid(out_valid),
        .out_first(out_first), .out_ready(out_ready), .set_done(set_done), .set_drop(set_drop), .crc_bad(crc_bad));
    // ************************
    // Helpers
    // ************************
    function automatic logic [7:0] bb(int s, int i);
        return 8'(i * 13 + s * 29 + 1);
    endfunction
    function automatic logic [31:0] sec(int s);
        return 32'h5A000000 + 32'(s) * 32'h00123457;
    endfunction
    function automatic logic [31:0] nsv(int s);
        return 32'h3ABCDEF0 - 32'(s) * 32'h01010101;
    endfunction
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        if (error_cnt == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic bail();
        error_cnt++;
        print_verdict();
    endtask
    // Expected bytes and sideband of one set
    task automatic build(int n, int f, int ch, logic sg, int s);
        logic [8:0]  pl[$];
        logic [95:0] h;
        logic [31:0] sc, ns;
        int          cap, m;
        sc = sec(s);
        ns = nsv(s);
        pl = {9'(n >> 8), 9'(n & 255)};
        for (int i = 0; i < n; i++) pl.push_back({1'b0, bb(s, i)});
        pl.push_back(9'h100);
        pl.push_back(9'h100);
        cap = sg ? 1428 : 1460;
        if (f == 0 || f > cap) f = cap;
        for (int o = 0; o < pl.size(); o += f) begin
            m = (pl.size() - o < f) ? pl.size() - o : f;
            h = {2'h2, 1'b0, sg, 4'h0, o == 0, 7'h4D, 16'(seq), sc[21:0], ns[29:20], 32'h0};
            for (int j = 0; j < 12; j++) expq.push_back({1'b0, h[95 - 8 * j -: 8]});
            for (int j = 0; j < m; j++) expq.push_back(pl[o + j]);
            sbq.push_back({sg, 16'(30064 + 100 * ch), 16'(12 + m)});
            seq++;
        end
    endtask
    task automatic feed(int n, int s);
        int w;
        for (int i = 0; i < n; i++) begin
            in_data <= bb(s, i);
            in_valid <= 1'b1;
            w = 0;
            do begin
                @(posedge clk);
                w++;
            end while (in_ready !== 1'b1 && w < 40000);
            if (w >= 40000) bail();
        end
        in_valid <= 1'b0;
    endtask
    task automatic run_set(int s);
        build(nt[s], ft[s], ct[s], gt[s], s);
        stall <= st[s];
        start <= 1'b1;
        body_len <= 16'(nt[s]);
        frag_max <= 11'(ft[s]);
        channel <= 2'(ct[s]);
        sign_en <= gt[s];
        boot_seconds <= sec(s);
        boot_nanoseconds <= nsv(s);
        @(posedge clk);
        start <= 1'b0;
        feed(nt[s], s);
        for (k = 0; busy !== 1'b0 && k < 40000; k++) @(posedge clk);
        if (k >= 40000) bail();
    endtask
    // ************************
    // Monitor and stimulus
    // ************************
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Compare every accepted byte except the check word bytes, and packet sideband
    always @(posedge clk) begin
        if (out_valid && out_ready) begin
            e = expq.size() ? expq.pop_front() : 9'h0FF;
            if (!e[8]) chk(out_data, e[7:0]);
            if (out_first) chk({pkt_ext, pkt_dst_port, pkt_len}, sbq.pop_front());
            if (out_first) chk(pkt_dst_addr, 32'hEF003330);
        end
        if (set_done) chk(crc_bad, 1'b0);
        if (set_drop) chk(set_drop, 1'b0);
        if (set_done) dones++;
        if (in_valid && !in_ready) saw_full <= 1'b1;
    end
    initial begin
        {reset, start, sign_en, in_valid, stall, saw_full} = 6'h20;
        {body_len, boot_seconds, boot_nanoseconds, channel, frag_max, in_data} = '0;
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        body_len <= 16'h0018;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        #1;
        chk({len_err, busy}, 2'h2);
        @(posedge clk);
        for (int s = 0; s < 5; s++) run_set(s);
        for (k = 0; expq.size() != 0 && k < 40000; k++) @(posedge clk);
        if (k >= 40000) bail();
        repeat (4) @(posedge clk);
        chk(dones, 5);
        chk(saw_full, 1'b1);
        chk(set_packets, 8'h02);
        chk(set_count, 16'h0005);
        print_verdict();
    end
endmodule
